// ---- logic/jle_consts.svh ----
// constants for the lane error and sync status register bank
// assumes an 8-bit serial control port with 12-bit register addresses
`ifndef JLE_CONSTS_SVH
`define JLE_CONSTS_SVH
// register addresses
`define JLE_ADDR_TABLE_MISS 12'h046E
`define JLE_ADDR_BAD_CTRL 12'h046F
`define JLE_ADDR_CODE_GROUP 12'h0470
`define JLE_ADDR_FRAME 12'h0471
`define JLE_ADDR_CHECKSUM 12'h0472
`define JLE_ADDR_ALIGN 12'h0473
// control register field positions
`define JLE_BIT_IRQ_CLEAR 7
`define JLE_BIT_CNT_DISABLE 6
`define JLE_BIT_CNT_CLEAR 5
`define JLE_LANE_MSB 2
// interrupt vector bit positions
`define JLE_VEC_CODE_GROUP 0
`define JLE_VEC_FRAME 1
`define JLE_VEC_CHECKSUM 2
`define JLE_VEC_ALIGN 3
`define JLE_VEC_BAD_CTRL 5
`define JLE_VEC_TABLE_MISS 6
// reset values
`define JLE_RST_BYTE 8'h00
`endif

// ---- logic/jle_pkg.sv ----
// types shared by the lane error and sync status register bank
// assumes the constants header defines all addresses and positions
package jle_pkg;
   // one access from the serial control port decoder
   typedef struct packed {
      logic wr;           // one-cycle write strobe
      logic [11:0] addr;  // register address
      logic [7:0] wdata;  // write byte
   } jle_reg_req_t;
   // live per-lane state from the lane decoders
   typedef struct packed {
      logic [7:0] code_group; // 1 = code group sync achieved
      logic [7:0] frame;      // 1 = frame sync achieved
      logic [7:0] checksum;   // 1 = last checksum good
      logic [7:0] align;      // 1 = initial lane alignment good
   } jle_lane_state_t;
endpackage : jle_pkg

// ---- logic/jle_lane_err.sv ----
// lane error counters, sticky error status and sync flag interrupts
// assumes all inputs come from logic on mclk; register port from the spi decoder
// Overview of operation
// - counter disable bit stops selected lane counters
// - counter clear bit zeroes selected lane counter
// - low three bits pick the target lane
// - bad control bit 7 clears lane interrupt
// - bad control status set at threshold
// - code group register shows per-lane lock
// - bit 7 write clears status interrupt
// - any code group loss requests sync
// - sync flags placed at vector bits 0,1,2,3
// - frame lock live; loss restarts sync
// - checksum register shows per-lane checksum result
// - alignment per lane; loss drives sync outputs
// - table miss status set at threshold
// - masked alignment failure pulls irq low
`timescale 1ns/1ps
`default_nettype none
`include "jle_consts.svh"
module jle_lane_err #(
   parameter int LANES = 8,   // lanes served
   parameter int CNT_W = 8    // error counter width
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire jle_pkg::jle_reg_req_t reg_req,
   output logic [7:0] reg_rdata,
   input wire jle_pkg::jle_lane_state_t lane_state,
   input wire logic [LANES-1:0] table_miss_err,
   input wire logic [LANES-1:0] bad_control_char_err,
   input wire logic [CNT_W-1:0] error_count_limit,
   input wire logic [7:0] irq_mask,
   output logic [7:0] irq_vector,
   output logic irq_n,
   output logic sync_request_out_a,
   output logic sync_request_out_b,
   output logic resync_start
);
   import jle_pkg::*;

   // the lane field is three bits wide and status bytes hold one bit per lane
   if (LANES < 1 || LANES > 8) begin : g_bad_lanes
      $error("jle_lane_err: LANES must be 1..8");
   end
   // wider counters would not fit the threshold compare
   if (CNT_W < 1 || CNT_W > 16) begin : g_bad_width
      $error("jle_lane_err: CNT_W must be 1..16");
   end

   // write decode, one strobe per register
   wire wr_tm = reg_req.wr && (reg_req.addr == `JLE_ADDR_TABLE_MISS);
   wire wr_bc = reg_req.wr && (reg_req.addr == `JLE_ADDR_BAD_CTRL);
   wire wr_cg = reg_req.wr && (reg_req.addr == `JLE_ADDR_CODE_GROUP);
   wire wr_fr = reg_req.wr && (reg_req.addr == `JLE_ADDR_FRAME);
   wire wr_ck = reg_req.wr && (reg_req.addr == `JLE_ADDR_CHECKSUM);
   wire wr_al = reg_req.wr && (reg_req.addr == `JLE_ADDR_ALIGN);
   // action bits of the write byte
   wire bit_irq_clr = reg_req.wdata[`JLE_BIT_IRQ_CLEAR];
   wire bit_cnt_dis = reg_req.wdata[`JLE_BIT_CNT_DISABLE];
   wire bit_cnt_clr = reg_req.wdata[`JLE_BIT_CNT_CLEAR];
   // lane chosen by the low field of the write byte
   wire [2:0] wr_lane = reg_req.wdata[`JLE_LANE_MSB:0];

   // sticky per-lane threshold status
   logic [LANES-1:0] tm_stat_q;
   logic [LANES-1:0] bc_stat_q;
   logic [LANES-1:0] tm_hit;  // count reaches limit this cycle
   logic [LANES-1:0] bc_hit;
   logic [LANES-1:0] tm_dis_q; // counter disabled per lane
   logic [LANES-1:0] bc_dis_q;

   // per-lane counters, two error kinds
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      logic [CNT_W-1:0] tm_cnt_q;
      logic [CNT_W-1:0] bc_cnt_q;
      // lane targeted by this cycle's write
      wire sel = (wr_lane == 3'(g));
      wire tm_clr = wr_tm && sel && bit_cnt_clr;
      wire bc_clr = wr_bc && sel && bit_cnt_clr;
      // counters saturate so the status never misses a wrap
      wire tm_inc = table_miss_err[g] && !tm_dis_q[g] && !(&tm_cnt_q);
      wire bc_inc = bad_control_char_err[g] && !bc_dis_q[g] && !(&bc_cnt_q);
      wire [CNT_W-1:0] tm_nxt = tm_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      wire [CNT_W-1:0] bc_nxt = bc_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      assign tm_hit[g] = tm_inc && !tm_clr && (tm_nxt == error_count_limit);
      assign bc_hit[g] = bc_inc && !bc_clr && (bc_nxt == error_count_limit);

      // counter update; clear beats a same-cycle count
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            tm_cnt_q <= '0;
            bc_cnt_q <= '0;
         end else begin
            if (tm_clr) begin
               tm_cnt_q <= '0;
            end else if (tm_inc) begin
               tm_cnt_q <= tm_nxt;
            end
            if (bc_clr) begin
               bc_cnt_q <= '0;
            end else if (bc_inc) begin
               bc_cnt_q <= bc_nxt;
            end
         end
      end

      // disable state: a write to the lane loads bit 6, zero re-enables
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            tm_dis_q[g] <= 1'b0;
            bc_dis_q[g] <= 1'b0;
         end else begin
            if (wr_tm && sel) begin
               tm_dis_q[g] <= bit_cnt_dis;
            end
            if (wr_bc && sel) begin
               bc_dis_q[g] <= bit_cnt_dis;
            end
         end
      end

      // sticky status; a hit in the clearing cycle wins
      always_ff @(posedge mclk or negedge rst_n) begin
         if (!rst_n) begin
            tm_stat_q[g] <= 1'b0;
            bc_stat_q[g] <= 1'b0;
         end else begin
            if (tm_hit[g]) begin
               tm_stat_q[g] <= 1'b1;
            end else if (wr_tm && sel && bit_irq_clr) begin
               tm_stat_q[g] <= 1'b0;
            end
            if (bc_hit[g]) begin
               bc_stat_q[g] <= 1'b1;
            end else if (wr_bc && sel && bit_irq_clr) begin
               bc_stat_q[g] <= 1'b0;
            end
         end
      end
   end

   // previous lane state for loss detection
   jle_lane_state_t prev_q;
   // falling edges: a lane lost its state this cycle
   wire [LANES-1:0] cg_loss = prev_q.code_group[LANES-1:0] & ~lane_state.code_group[LANES-1:0];
   wire [LANES-1:0] fr_loss = prev_q.frame[LANES-1:0] & ~lane_state.frame[LANES-1:0];
   wire [LANES-1:0] ck_loss = prev_q.checksum[LANES-1:0] & ~lane_state.checksum[LANES-1:0];
   wire [LANES-1:0] al_loss = prev_q.align[LANES-1:0] & ~lane_state.align[LANES-1:0];

   // sticky interrupt flags of the four sync status registers
   logic cg_irq_q;
   logic fr_irq_q;
   logic ck_irq_q;
   logic al_irq_q;

   // loss history; reset value is all lost so power-up does not flag
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         prev_q <= '0;
      end else begin
         prev_q <= lane_state;
      end
   end

   // flag set on any lane loss, cleared by bit 7 write; set wins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         cg_irq_q <= 1'b0;
         fr_irq_q <= 1'b0;
         ck_irq_q <= 1'b0;
         al_irq_q <= 1'b0;
      end else begin
         cg_irq_q <= (|cg_loss) | (cg_irq_q & ~(wr_cg & bit_irq_clr));
         fr_irq_q <= (|fr_loss) | (fr_irq_q & ~(wr_fr & bit_irq_clr));
         ck_irq_q <= (|ck_loss) | (ck_irq_q & ~(wr_ck & bit_irq_clr));
         al_irq_q <= (|al_loss) | (al_irq_q & ~(wr_al & bit_irq_clr));
      end
   end

   // vector layout for the outer interrupt register
   logic [7:0] vec_d;
   always_comb begin
      vec_d = `JLE_RST_BYTE;
      vec_d[`JLE_VEC_CODE_GROUP] = cg_irq_q;
      vec_d[`JLE_VEC_FRAME] = fr_irq_q;
      vec_d[`JLE_VEC_CHECKSUM] = ck_irq_q;
      vec_d[`JLE_VEC_ALIGN] = al_irq_q;
      vec_d[`JLE_VEC_BAD_CTRL] = |bc_stat_q;
      vec_d[`JLE_VEC_TABLE_MISS] = |tm_stat_q;
   end

   // sync request while any lane lacks code group lock or alignment
   wire sync_req_d = ~(&lane_state.code_group[LANES-1:0]) | ~(&lane_state.align[LANES-1:0]);

   // status outputs registered so they never glitch on the pins
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         irq_vector <= `JLE_RST_BYTE;
         irq_n <= 1'b1;
         sync_request_out_a <= 1'b1;
         sync_request_out_b <= 1'b1;
         resync_start <= 1'b0;
      end else begin
         irq_vector <= vec_d;
         irq_n <= ~(|(vec_d & irq_mask));
         sync_request_out_a <= sync_req_d;
         sync_request_out_b <= sync_req_d;
         resync_start <= |fr_loss;
      end
   end

   // read mux; sync status registers show the live lane state
   logic [7:0] rd_d;
   logic [7:0] tm_byte;
   logic [7:0] bc_byte;
   always_comb begin
      tm_byte = `JLE_RST_BYTE;
      bc_byte = `JLE_RST_BYTE;
      tm_byte[LANES-1:0] = tm_stat_q;
      bc_byte[LANES-1:0] = bc_stat_q;
      case (reg_req.addr)
         `JLE_ADDR_TABLE_MISS: rd_d = tm_byte;
         `JLE_ADDR_BAD_CTRL: rd_d = bc_byte;
         `JLE_ADDR_CODE_GROUP: rd_d = lane_state.code_group;
         `JLE_ADDR_FRAME: rd_d = lane_state.frame;
         `JLE_ADDR_CHECKSUM: rd_d = lane_state.checksum;
         `JLE_ADDR_ALIGN: rd_d = lane_state.align;
         default: rd_d = `JLE_RST_BYTE; // unmapped reads as zero
      endcase
   end

   // read data one cycle after the address
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `JLE_RST_BYTE;
      end else begin
         reg_rdata <= rd_d;
      end
   end
endmodule : jle_lane_err
`default_nettype wire

// ---- verification/jle_lane_err_properties.sv ----
// port assertions for the lane error bank
// assumes one mclk domain; bound to every jle_lane_err
`timescale 1ns/1ps
`default_nettype none
`include "jle_consts.svh"
module jle_lane_err_properties (
   input wire logic mclk,
   input wire logic rst_n,
   input wire jle_pkg::jle_reg_req_t reg_req,
   input wire logic [7:0] reg_rdata,
   input wire jle_pkg::jle_lane_state_t lane_state,
   input wire logic [7:0] irq_mask,
   input wire logic [7:0] irq_vector,
   input wire logic irq_n,
   input wire logic sync_request_out_a,
   input wire logic sync_request_out_b,
   input wire logic resync_start
);
   import jle_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // a lane bit dropped between two edges
   sequence frame_fall; |($past(lane_state.frame) & ~lane_state.frame); endsequence
   sequence group_fall; |($past(lane_state.code_group) & ~lane_state.code_group); endsequence
   chk_resync_on_loss: assert property (frame_fall |=> resync_start)
      else $error("no resync pulse after frame loss");
   chk_vec_group: assert property (group_fall |-> ##2 irq_vector[0])
      else $error("code group loss not flagged");
   chk_vec_frame: assert property (frame_fall |-> ##2 irq_vector[1])
      else $error("frame loss not flagged");
   chk_sync_follows: assert property (1 |=> sync_request_out_a == ~&$past(lane_state.code_group & lane_state.align))
      else $error("sync request wrong");
   chk_sync_pair: assert property (sync_request_out_b == sync_request_out_a)
      else $error("sync outputs differ");
   chk_irq_from_vec: assert property (1 |=> irq_n == ~|(irq_vector & $past(irq_mask)))
      else $error("irq level wrong");
   chk_live_group: assert property (reg_req.addr == `JLE_ADDR_CODE_GROUP |=> reg_rdata == $past(lane_state.code_group))
      else $error("code group read wrong");
   chk_live_frame: assert property (reg_req.addr == `JLE_ADDR_FRAME |=> reg_rdata == $past(lane_state.frame))
      else $error("frame read wrong");
   chk_vec_spare: assert property (irq_vector[7] == 1'b0 && irq_vector[4] == 1'b0)
      else $error("spare vector bit set");
endmodule : jle_lane_err_properties
bind jle_lane_err jle_lane_err_properties u_props (.mclk(mclk), .rst_n(rst_n), .reg_req(reg_req),
   .reg_rdata(reg_rdata), .lane_state(lane_state), .irq_mask(irq_mask), .irq_vector(irq_vector),
   .irq_n(irq_n), .sync_request_out_a(sync_request_out_a), .sync_request_out_b(sync_request_out_b),
   .resync_start(resync_start));
`default_nettype wire

// ---- verification/jle_tx_model.sv ----
// far-end transmitter model: lane states and character error pulses
// assumes bench commands change on the falling edge of mclk
`timescale 1ns/1ps
`default_nettype none
module jle_tx_model (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic slow,
   input wire jle_pkg::jle_lane_state_t fault,
   input wire logic [7:0] miss_cmd,
   input wire logic [7:0] bad_cmd,
   output var jle_pkg::jle_lane_state_t lane_state,
   output logic [7:0] table_miss_err,
   output logic [7:0] bad_control_char_err
);
   import jle_pkg::*;
   logic tick_q; // pacing toggle, slow links settle every other cycle
   // link starts all-lost after reset and comes up on the next edge, or on the second edge when slow
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         tick_q <= 1'b0;
         lane_state <= '0;
         table_miss_err <= 8'h00;
         bad_control_char_err <= 8'h00;
      end else begin
         tick_q <= ~tick_q;
         table_miss_err <= miss_cmd;
         bad_control_char_err <= bad_cmd;
         if (!slow || tick_q) lane_state <= ~fault;
      end
   end
endmodule : jle_tx_model
`default_nettype wire

// ---- verification/jle_lane_err_tb.sv ----
// bench for the lane error bank: counter rows, then sync flags and reset
// assumes the far-end model feeds lane state and error pulses
`timescale 1ns/1ps
`default_nettype none
module jle_lane_err_tb;
   import jle_pkg::*;
   typedef struct {logic [11:0] wa; logic [7:0] wd; logic [7:0] ln; int n; logic [11:0] ra; logic [7:0] st;
      logic [7:0] vc;} jle_row_t;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic slow = 1'b0;
   jle_reg_req_t req = '0;
   jle_lane_state_t fault = '0;
   jle_lane_state_t ls;
   logic [7:0] miss = 8'h00, bad = 8'h00, mask = 8'h00, limit = 8'h03;
   logic [7:0] rdata, vec, tm, bc;
   logic irq_n, sa, sb, rs;
   int failures = 0, total_checks = 0;
   // control write, error burst, status byte and vector expected (limit 3)
   jle_row_t rows [7] = '{'{12'h046E, 8'h22, 8'h04, 3, 12'h046E, 8'h04, 8'h40},
      '{12'h046F, 8'h41, 8'h02, 3, 12'h046F, 8'h00, 8'h40}, '{12'h046F, 8'h21, 8'h02, 3, 12'h046F, 8'h02, 8'h60},
      '{12'h046F, 8'h81, 8'h00, 0, 12'h046F, 8'h00, 8'h40}, '{12'h046E, 8'hA2, 8'h04, 2, 12'h046E, 8'h00, 8'h00},
      '{12'h0400, 8'hFF, 8'h04, 1, 12'h046E, 8'h04, 8'h40}, '{12'h046F, 8'h3B, 8'h08, 3, 12'h046F, 8'h08, 8'h60}};
   jle_tx_model u_far (.mclk(mclk), .rst_n(rst_n), .slow(slow), .fault(fault), .miss_cmd(miss), .bad_cmd(bad),
      .lane_state(ls), .table_miss_err(tm), .bad_control_char_err(bc));
   jle_lane_err DUT (.mclk(mclk), .rst_n(rst_n), .reg_req(req), .reg_rdata(rdata), .lane_state(ls),
      .table_miss_err(tm), .bad_control_char_err(bc), .error_count_limit(limit), .irq_mask(mask),
      .irq_vector(vec), .irq_n(irq_n), .sync_request_out_a(sa), .sync_request_out_b(sb), .resync_start(rs));
   always #5 mclk = ~mclk;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one-cycle write strobe, released a full cycle later
   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(negedge mclk) req = '{1'b1, a, d};
      @(negedge mclk) req.wr = 1'b0;
   endtask : wr
   // read data lands one edge after the address
   task automatic rd(input logic [11:0] a, input logic [7:0] exp);
      @(negedge mclk) req.addr = a;
      @(negedge mclk) check(32'(rdata), 32'(exp));
   endtask : rd
   task automatic report_and_stop();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : report_and_stop
   // hang guard
   initial begin
      #100us;
      failures++;
      report_and_stop();
   end
   initial begin
      repeat (12) @(negedge mclk);
      rst_n = 1'b1;
      repeat (4) @(negedge mclk);
      foreach (rows[i]) begin
         wr(rows[i].wa, rows[i].wd);
         repeat (rows[i].n) begin
            @(negedge mclk) {miss, bad} = (rows[i].ra == 12'h046E) ? {rows[i].ln, 8'h00} : {8'h00, rows[i].ln};
            @(negedge mclk) {miss, bad} = 16'h0000;
         end
         repeat (4) @(negedge mclk);
         rd(rows[i].ra, rows[i].st);
         check(32'(vec), 32'(rows[i].vc));
      end
      // a threshold of one flags the very first error on lane 0
      limit = 8'h01;
      wr(12'h046E, 8'h20);
      @(negedge mclk) miss = 8'h01;
      @(negedge mclk) miss = 8'h00;
      repeat (4) @(negedge mclk);
      rd(12'h046E, 8'h05);
      wr(12'h046E, 8'h80);
      wr(12'h046E, 8'h82);
      wr(12'h046F, 8'h83);
      repeat (4) @(negedge mclk);
      check(32'(vec), 32'h0);
      // one lane lost per status kind, on a slow link, then cleared by bit 7
      slow = 1'b1;
      for (int i = 0; i < 4; i++) begin
         mask = 8'h01 << i;
         fault = 32'h1 << (8 * (3 - i) + 2 * i + 1);
         repeat (6) @(negedge mclk);
         rd(12'(12'h0470 + i), 8'(~(8'h01 << (2 * i + 1))));
         check(32'(vec), 32'(8'h01 << i));
         check({irq_n, sa}, {1'b0, 1'(i == 0 || i == 3)});
         fault = '0;
         wr(12'(12'h0470 + i), 8'h80);
         repeat (6) @(negedge mclk);
         check({vec, irq_n, sa, sb}, 11'b00000000100);
      end
      rd(12'h0400, 8'h00);
      @(negedge mclk) rst_n = 1'b0;
      @(negedge mclk) check({rdata, vec, irq_n, sa, sb, rs}, 20'h0000E);
      report_and_stop();
   end
endmodule : jle_lane_err_tb
`default_nettype wire
